// file: hw/sac_pkg.sv
// constants, register map and state codes of the converter control block
package sac_pkg;

  // printed register offsets are register indices; byte address is four times the index
  localparam logic [15:0] MODE_IDX   = 16'hffbc;
  localparam logic [15:0] RESULT_IDX = 16'hffbd;
  localparam logic [15:0] START_IDX  = 16'hffbe;
  localparam logic [15:0] PIN_IDX    = 16'hffef;
  localparam logic [15:0] REQ_IDX    = 16'hfff3;
  localparam logic [15:0] EN_IDX     = 16'hfff4;

  localparam logic [31:0] MODE_ADDR   = {14'h0000, MODE_IDX, 2'b00};
  localparam logic [31:0] RESULT_ADDR = {14'h0000, RESULT_IDX, 2'b00};
  localparam logic [31:0] START_ADDR  = {14'h0000, START_IDX, 2'b00};
  localparam logic [31:0] PIN_ADDR    = {14'h0000, PIN_IDX, 2'b00};
  localparam logic [31:0] REQ_ADDR    = {14'h0000, REQ_IDX, 2'b00};
  localparam logic [31:0] EN_ADDR     = {14'h0000, EN_IDX, 2'b00};

  // field positions
  localparam int unsigned SPEED_BIT = 7;
  localparam int unsigned CH_MSB    = 2;
  localparam int unsigned CH_LSB    = 0;
  localparam int unsigned RUN_BIT   = 7;
  localparam int unsigned REQ_BIT   = 0;
  localparam int unsigned EN_BIT    = 0;

  // reset values and bits that always read one
  localparam logic [7:0] MODE_RST       = 8'h78;
  localparam logic [7:0] START_RST      = 8'h7f;
  localparam logic [7:0] PIN_RST        = 8'h00;
  localparam logic [7:0] MODE_ONES      = 8'h78;
  localparam logic [7:0] START_ONES     = 8'h7f;
  localparam logic       REQ_RST        = 1'b0;
  localparam logic       EN_RST         = 1'b0;

  // conversion timing in system clock cycles
  localparam int unsigned SLOW_PERIOD_CYC = 62;
  localparam int unsigned FAST_PERIOD_CYC = 31;
  localparam int unsigned SLOW_DIV        = SLOW_PERIOD_CYC / FAST_PERIOD_CYC;
  localparam int unsigned CONV_UNITS      = FAST_PERIOD_CYC;
  localparam int unsigned SAMPLE_UNITS    = 7;
  localparam int unsigned BIT_UNITS       = 3;
  localparam int unsigned RESULT_BITS     = 8;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_SAMPLE = 3'b010,
    ST_CONV   = 3'b100
  } sac_state_t;

endpackage

// file: hw/sac_sar_reg.sv
// successive-approximation register: trial code and bit pointer
`timescale 1ns/100ps
module sac_sar_reg #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             load_i,
  input  wire logic             decide_i,
  input  wire logic             comp_i,
  output logic      [WIDTH-1:0] code_o,
  output logic      [WIDTH-1:0] resolved_o
);

  if (WIDTH < 2) begin : g_chk
    $error("sac_sar_reg: WIDTH must be at least 2");
  end

  typedef struct packed {
    logic [WIDTH-1:0] code;
    logic [WIDTH-1:0] ptr;
  } sac_sar_t;

  localparam logic [WIDTH-1:0] MSB_ONE = {1'b1, {(WIDTH-1){1'b0}}};

  sac_sar_t r;
  sac_sar_t next_r;
  logic [WIDTH-1:0] resolved;

  always_comb begin
    next_r = r;
    // keep the trial bit when the input is at or above the trial level
    resolved = comp_i ? r.code : (r.code & ~r.ptr);
    if (rst_i) begin
      next_r.code = '0;
      next_r.ptr  = '0;
    end else if (load_i) begin
      next_r.code = MSB_ONE;
      next_r.ptr  = MSB_ONE;
    end else if (decide_i) begin
      next_r.code = resolved | (r.ptr >> 1);
      next_r.ptr  = r.ptr >> 1;
    end
  end

  always_ff @(posedge clk_i) begin
    r <= next_r;
  end

  assign code_o     = r.code;
  assign resolved_o = resolved;

endmodule

// file: hw/sac_adc_ctrl.sv
// converter control: register file on ahb-lite, conversion sequencer, pin select
// Operation
// - resolve selected input by successive approximation into an 8-bit unsigned code
// - result register readable anytime, value undefined during conversion
// - stored result unchanged until the next conversion completes
// - reset leaves the result register untouched
// - mode register resets to 78h: speed and channel cleared, bits 6-3 one
// - speed bit 0 gives 62 cycles, 1 gives 31 cycles per conversion
// - 3-bit channel field selects input 0 to 7, reset selects input 0
// - reserved mode and start bits read one, ignore writes; start resets 7fh
// - writing 1 to run flag starts; flag reads 1 throughout conversion
// - on completion load result and clear run flag in the same cycle
// - writing 0 to run flag stops; flag 0 means idle
// - completion sets the conversion-done request bit
// - interrupt raised only while the done enable bit is 1
// - write-only pin select: 0 digital input, 1 analog input per pin
// - pin select resets to 00h, all pins digital
`timescale 1ns/100ps
module sac_adc_ctrl (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  input  wire logic        comp_i,
  output logic             sample_hold_o,
  output logic      [7:0]  dac_code_o,
  output logic      [2:0]  channel_o,
  output logic      [7:0]  analog_pin_enable_bits_o,
  output logic             conversion_done_request_o,
  output logic             conversion_done_irq_o
);

  typedef struct packed {
    sac_pkg::sac_state_t st;
    logic                conversion_run_flag;
    logic                conversion_speed_select;
    logic [2:0]          channel_select_field;
    logic [7:0]          analog_pin_enable_bits;
    logic [7:0]          result_bits;
    logic                conversion_done_request;
    logic                conversion_done_enable;
    logic [4:0]          unit;
    logic                sub;
    logic [1:0]          step;
    logic                wr_pend;
    logic                rd_pend;
    logic [31:0]         addr_q;
    logic [31:0]         rdata;
    logic                comp_s1;
    logic                comp_s2;
    logic [5:0]          run_cnt;
    logic                result_valid;
  } sac_regs_t;

  localparam logic [4:0] LAST_SAMPLE = 5'(sac_pkg::SAMPLE_UNITS - 1);
  localparam logic [4:0] LAST_UNIT   = 5'(sac_pkg::CONV_UNITS - 1);
  localparam logic [1:0] LAST_STEP   = 2'(sac_pkg::BIT_UNITS - 1);
  localparam logic [5:0] FAST_LAST   = 6'(sac_pkg::FAST_PERIOD_CYC - 1);
  localparam logic [5:0] SLOW_LAST   = 6'(sac_pkg::SLOW_PERIOD_CYC - 1);

  if (sac_pkg::SLOW_DIV != 2 || sac_pkg::RESULT_BITS * sac_pkg::BIT_UNITS
      + sac_pkg::SAMPLE_UNITS != sac_pkg::CONV_UNITS) begin : g_chk
    $error("sac_adc_ctrl: conversion schedule does not fit the period");
  end

  sac_regs_t r;
  sac_regs_t next_r;
  logic      sar_load;
  logic      sar_decide;
  logic      unit_end;
  logic      complete;
  logic      start_wr;
  logic      stop_wr;
  logic [7:0] sar_code;
  logic [7:0] sar_resolved;

  // read value of one register word
  function automatic logic [31:0] read_word(input logic [31:0] a, input sac_regs_t s);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (a)
      sac_pkg::MODE_ADDR: begin
        w[7:0] = sac_pkg::MODE_ONES;
        w[sac_pkg::SPEED_BIT] = s.conversion_speed_select;
        w[sac_pkg::CH_MSB:sac_pkg::CH_LSB] = s.channel_select_field;
      end
      sac_pkg::START_ADDR: begin
        w[7:0] = sac_pkg::START_ONES;
        w[sac_pkg::RUN_BIT] = s.conversion_run_flag;
      end
      sac_pkg::RESULT_ADDR: w[7:0] = s.result_bits;
      sac_pkg::REQ_ADDR: w[sac_pkg::REQ_BIT] = s.conversion_done_request;
      sac_pkg::EN_ADDR: w[sac_pkg::EN_BIT] = s.conversion_done_enable;
      default: w = 32'h0000_0000; // pin select is write-only, unmapped reads zero
    endcase
    return w;
  endfunction

  always_comb begin
    next_r     = r;
    sar_load   = 1'b0;
    sar_decide = 1'b0;
    complete   = 1'b0;
    start_wr   = 1'b0;
    stop_wr    = 1'b0;
    unit_end   = r.conversion_speed_select ? 1'b1 : r.sub;

    next_r.comp_s1 = comp_i;
    next_r.comp_s2 = r.comp_s1;

    // address phase
    if (hsel_i && hready_i && htrans_i[1]) begin
      next_r.wr_pend = hwrite_i;
      next_r.rd_pend = !hwrite_i;
      next_r.addr_q  = haddr_i;
      if (!hwrite_i) begin
        next_r.rdata = read_word(haddr_i, r);
      end
    end else begin
      next_r.wr_pend = 1'b0;
      next_r.rd_pend = 1'b0;
    end

    // data phase writes; reserved bits have no storage
    if (r.wr_pend) begin
      case (r.addr_q)
        sac_pkg::MODE_ADDR: begin
          next_r.conversion_speed_select = hwdata_i[sac_pkg::SPEED_BIT];
          next_r.channel_select_field    = hwdata_i[sac_pkg::CH_MSB:sac_pkg::CH_LSB];
        end
        sac_pkg::START_ADDR: begin
          start_wr = hwdata_i[sac_pkg::RUN_BIT];
          stop_wr  = !hwdata_i[sac_pkg::RUN_BIT];
        end
        sac_pkg::PIN_ADDR: next_r.analog_pin_enable_bits = hwdata_i[7:0];
        sac_pkg::REQ_ADDR: begin
          if (!hwdata_i[sac_pkg::REQ_BIT]) begin
            next_r.conversion_done_request = 1'b0;
          end
        end
        sac_pkg::EN_ADDR: next_r.conversion_done_enable = hwdata_i[sac_pkg::EN_BIT];
        default: next_r.wr_pend = next_r.wr_pend;
      endcase
    end

    // sequencer
    if (r.conversion_run_flag) begin
      next_r.run_cnt = r.run_cnt + 6'd1;
    end
    if (r.st != sac_pkg::ST_IDLE) begin
      next_r.sub = r.conversion_speed_select ? 1'b0 : ~r.sub;
      if (unit_end) begin
        next_r.unit = r.unit + 5'd1;
      end
    end
    case (r.st)
      sac_pkg::ST_IDLE: begin
        next_r.unit = 5'd0;
      end
      sac_pkg::ST_SAMPLE: begin
        if (unit_end && r.unit == LAST_SAMPLE) begin
          next_r.st   = sac_pkg::ST_CONV;
          next_r.step = 2'd0;
        end
      end
      sac_pkg::ST_CONV: begin
        if (unit_end) begin
          if (r.step == LAST_STEP) begin
            next_r.step = 2'd0;
            sar_decide  = 1'b1;
          end else begin
            next_r.step = r.step + 2'd1;
          end
          if (r.unit == LAST_UNIT) begin
            complete                       = 1'b1;
            next_r.st                      = sac_pkg::ST_IDLE;
            next_r.conversion_run_flag     = 1'b0;
            next_r.result_bits             = sar_resolved;
            next_r.result_valid            = 1'b1;
            next_r.conversion_done_request = 1'b1;
          end
        end
      end
      default: begin
        next_r.st                  = sac_pkg::ST_IDLE;
        next_r.conversion_run_flag = 1'b0;
      end
    endcase

    // software start overrides the sequencer; stop applies only if no conversion completes in the same cycle
    if (start_wr) begin
      next_r.st                  = sac_pkg::ST_SAMPLE;
      next_r.conversion_run_flag = 1'b1;
      next_r.unit                = 5'd0;
      next_r.sub                 = 1'b0;
      next_r.step                = 2'd0;
      next_r.run_cnt             = 6'd0;
      sar_load                   = 1'b1;
    end else if (stop_wr && !complete) begin
      next_r.st                  = sac_pkg::ST_IDLE;
      next_r.conversion_run_flag = 1'b0;
    end

    // synchronous reset; result register keeps its content
    if (rst_i) begin
      next_r.st                      = sac_pkg::ST_IDLE;
      next_r.conversion_run_flag     = sac_pkg::START_RST[sac_pkg::RUN_BIT];
      next_r.conversion_speed_select = sac_pkg::MODE_RST[sac_pkg::SPEED_BIT];
      next_r.channel_select_field    = sac_pkg::MODE_RST[sac_pkg::CH_MSB:sac_pkg::CH_LSB];
      next_r.analog_pin_enable_bits  = sac_pkg::PIN_RST;
      next_r.result_bits             = r.result_bits;
      next_r.conversion_done_request = sac_pkg::REQ_RST;
      next_r.conversion_done_enable  = sac_pkg::EN_RST;
      next_r.unit                    = 5'd0;
      next_r.sub                     = 1'b0;
      next_r.step                    = 2'd0;
      next_r.wr_pend                 = 1'b0;
      next_r.rd_pend                 = 1'b0;
      next_r.addr_q                  = 32'h0000_0000;
      next_r.rdata                   = 32'h0000_0000;
      next_r.run_cnt                 = 6'd0;
      next_r.result_valid            = 1'b0;
      sar_load                       = 1'b0;
      sar_decide                     = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    r <= next_r;
  end

  sac_sar_reg #(
    .WIDTH (sac_pkg::RESULT_BITS)
  ) u_sar (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .load_i     (sar_load),
    .decide_i   (sar_decide),
    .comp_i     (r.comp_s2),
    .code_o     (sar_code),
    .resolved_o (sar_resolved)
  );

  assign hrdata_o                  = r.rdata;
  assign hreadyout_o               = 1'b1;
  assign hresp_o                   = 1'b0;
  assign sample_hold_o             = (r.st == sac_pkg::ST_SAMPLE);
  assign dac_code_o                = sar_code;
  assign channel_o                 = r.channel_select_field;
  assign analog_pin_enable_bits_o  = r.analog_pin_enable_bits;
  assign conversion_done_request_o = r.conversion_done_request;
  assign conversion_done_irq_o     = r.conversion_done_request
                                     & r.conversion_done_enable;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  period_length_a: assert property (
    complete |-> r.run_cnt == (r.conversion_speed_select ? FAST_LAST : SLOW_LAST))
    else $error("conversion period length wrong");

  flag_result_a: assert property (
    complete |=> r.conversion_run_flag == $past(start_wr)
    && r.result_bits == $past(sar_resolved))
    else $error("result load and flag clear not together");

  result_hold_a: assert property (
    r.result_valid && !complete |=> $stable(r.result_bits))
    else $error("result changed without a completion");

  early_stop_a: assert property (
    stop_wr && r.conversion_run_flag && !complete
    |=> !r.conversion_run_flag && r.st == sac_pkg::ST_IDLE
        && r.conversion_done_request == $past(r.conversion_done_request)
        && $stable(r.result_bits))
    else $error("early stop disturbed request or result");

  request_set_a: assert property (
    complete |=> r.conversion_done_request)
    else $error("completion did not set request");

  irq_gate_a: assert property (
    complete |=> conversion_done_request_o
    && conversion_done_irq_o == r.conversion_done_enable)
    else $error("completion interrupt does not follow the enable");

  irq_masked_a: assert property (
    !r.conversion_done_enable |-> !conversion_done_irq_o)
    else $error("interrupt raised while disabled");

  mode_read_a: assert property (
    r.rd_pend && r.addr_q == sac_pkg::MODE_ADDR
    |-> hrdata_o[6:3] == 4'hf && hrdata_o[31:8] == 24'h00_0000)
    else $error("mode register reserved bits wrong");

  reset_values_a: assert property (
    $past(rst_i) |-> !r.conversion_run_flag && !r.conversion_speed_select
    && channel_o == 3'h0 && analog_pin_enable_bits_o == 8'h00)
    else $error("reset values wrong");

  start_run_a: assert property (
    start_wr |=> r.conversion_run_flag && sample_hold_o && dac_code_o == 8'h80
    ##1 r.conversion_run_flag)
    else $error("start did not begin a conversion");

  channel_write_a: assert property (
    r.wr_pend && r.addr_q == sac_pkg::MODE_ADDR
    |=> channel_o == $past(hwdata_i[2:0]))
    else $error("channel field not written");

  pin_write_a: assert property (
    r.wr_pend && r.addr_q == sac_pkg::PIN_ADDR
    |=> analog_pin_enable_bits_o == $past(hwdata_i[7:0]))
    else $error("pin select not written");

  fast_done_c: cover property (complete && r.conversion_speed_select);
  slow_done_c: cover property (complete && !r.conversion_speed_select);
  stop_mid_c: cover property (stop_wr && r.st == sac_pkg::ST_CONV);
  clear_race_c: cover property (complete && r.wr_pend && r.addr_q == sac_pkg::REQ_ADDR);

endmodule

// file: dv/tb_sar_adc_control.sv
// self-checking testbench of the converter control block
`timescale 1ns/100ps
`define chk(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, a, e); end end
module tb_sar_adc_control;
  logic        clk_i;
  logic        rst_i;
  logic        hsel_i;
  logic [31:0] haddr_i;
  logic [1:0]  htrans_i;
  logic        hwrite_i;
  logic [31:0] hwdata_i;
  logic        comp_i;
  logic [7:0]  ain;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        hresp_o;
  logic        sample_hold_o;
  logic [7:0]  dac_code_o;
  logic [2:0]  channel_o;
  logic [7:0]  analog_pin_enable_bits_o;
  logic        conversion_done_request_o;
  logic        conversion_done_irq_o;
  int          fails;
  int          num_checks;

  sac_adc_ctrl u_dut (
    .clk_i                     (clk_i),
    .rst_i                     (rst_i),
    .hsel_i                    (hsel_i),
    .haddr_i                   (haddr_i),
    .htrans_i                  (htrans_i),
    .hwrite_i                  (hwrite_i),
    .hsize_i                   (3'b010),
    .hwdata_i                  (hwdata_i),
    .hready_i                  (hreadyout_o),
    .hrdata_o                  (hrdata_o),
    .hreadyout_o               (hreadyout_o),
    .hresp_o                   (hresp_o),
    .comp_i                    (comp_i),
    .sample_hold_o             (sample_hold_o),
    .dac_code_o                (dac_code_o),
    .channel_o                 (channel_o),
    .analog_pin_enable_bits_o  (analog_pin_enable_bits_o),
    .conversion_done_request_o (conversion_done_request_o),
    .conversion_done_irq_o     (conversion_done_irq_o)
  );

  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  // comparator of an ideal analog input against the trial code, settles at once
  assign comp_i = (ain >= dac_code_o);

  task automatic report_and_stop;
    if (fails == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic wait_ready;
    @(posedge clk_i);
    while (hreadyout_o !== 1'b1) @(posedge clk_i);
  endtask

  task automatic bus_write(input logic [31:0] a, input logic [7:0] d);
    hsel_i   <= 1'b1;
    haddr_i  <= a;
    htrans_i <= 2'b10;
    hwrite_i <= 1'b1;
    wait_ready();
    htrans_i <= 2'b00;
    hwdata_i <= {24'h000000, d};
    wait_ready();
  endtask

  task automatic bus_read(input logic [31:0] a, output logic [31:0] d);
    hsel_i   <= 1'b1;
    haddr_i  <= a;
    htrans_i <= 2'b10;
    hwrite_i <= 1'b0;
    wait_ready();
    htrans_i <= 2'b00;
    wait_ready();
    d = hrdata_o;
  endtask

  task automatic do_reset;
    rst_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
  endtask

  task automatic t_reset_vals;
    logic [31:0] rd;
    bus_read(sac_pkg::MODE_ADDR, rd);
    `chk(rd, 32'h00000078)
    bus_read(sac_pkg::START_ADDR, rd);
    `chk(rd, 32'h0000007f)
    bus_read(sac_pkg::REQ_ADDR, rd);
    `chk(rd[0], 1'b0)
    `chk(analog_pin_enable_bits_o, 8'h00)
    `chk(channel_o, 3'h0)
    `chk(conversion_done_irq_o, 1'b0)
    `chk(hreadyout_o, 1'b1)
    `chk(hresp_o, 1'b0)
  endtask

  task automatic t_fields;
    logic [31:0] rd;
    for (int c = 0; c < 8; c++) begin
      bus_write(sac_pkg::MODE_ADDR, {c[0], 4'h0, c[2:0]});
      bus_read(sac_pkg::MODE_ADDR, rd);
      `chk(rd[7:0], {c[0], 4'hf, c[2:0]})
      `chk(channel_o, c[2:0])
    end
    bus_write(sac_pkg::START_ADDR, 8'h00);
    bus_read(sac_pkg::START_ADDR, rd);
    `chk(rd, 32'h0000007f)
    bus_write(sac_pkg::PIN_ADDR, 8'ha5);
    @(posedge clk_i);
    `chk(analog_pin_enable_bits_o, 8'ha5)
    bus_read(32'h00000000, rd);
    `chk(rd, 32'h00000000)
  endtask

  task automatic t_conv(input logic sp, input logic [7:0] v);
    logic [31:0] rd;
    int          n;
    int          p;
    p   = sp ? 31 : 62;
    ain = v;
    bus_write(sac_pkg::MODE_ADDR, {sp, 7'h03});
    bus_write(sac_pkg::PIN_ADDR, 8'h08);
    bus_write(sac_pkg::REQ_ADDR, 8'h00);
    bus_write(sac_pkg::START_ADDR, 8'h80);
    bus_read(sac_pkg::START_ADDR, rd);
    n = 2;
    `chk(rd[7:0], 8'hff)
    #1;
    `chk(sample_hold_o, 1'b1)
    `chk(dac_code_o, 8'h80)
    `chk(channel_o, 3'h3)
    while (conversion_done_request_o !== 1'b1 && n < 300) begin
      @(posedge clk_i);
      n++;
      #1;
    end
    `chk(n, p)
    bus_read(sac_pkg::START_ADDR, rd);
    `chk(rd[7:0], 8'h7f)
    bus_read(sac_pkg::RESULT_ADDR, rd);
    `chk(rd[7:0], v)
    bus_read(sac_pkg::REQ_ADDR, rd);
    `chk(rd[0], 1'b1)
    `chk(conversion_done_irq_o, 1'b0)
    bus_write(sac_pkg::EN_ADDR, 8'h01);
    @(posedge clk_i);
    `chk(conversion_done_irq_o, 1'b1)
    bus_write(sac_pkg::REQ_ADDR, 8'h00);
    @(posedge clk_i);
    `chk(conversion_done_irq_o, 1'b0)
    bus_write(sac_pkg::EN_ADDR, 8'h00);
  endtask

  task automatic t_stop(input logic [7:0] prev);
    logic [31:0] rd;
    ain = ~prev;
    bus_write(sac_pkg::START_ADDR, 8'h80);
    repeat (10) @(posedge clk_i);
    bus_write(sac_pkg::START_ADDR, 8'h00);
    bus_read(sac_pkg::START_ADDR, rd);
    `chk(rd[7:0], 8'h7f)
    repeat (70) @(posedge clk_i);
    `chk(conversion_done_request_o, 1'b0)
    bus_read(sac_pkg::RESULT_ADDR, rd);
    `chk(rd[7:0], prev)
  endtask

  task automatic t_keep_on_reset(input logic [7:0] prev);
    logic [31:0] rd;
    ain = 8'h3c;
    do_reset();
    t_reset_vals();
    bus_read(sac_pkg::RESULT_ADDR, rd);
    `chk(rd[7:0], prev)
  endtask

  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    report_and_stop();
  end

  initial begin
    fails      = 0;
    num_checks = 0;
    rst_i      = 1'b1;
    hsel_i     = 1'b0;
    haddr_i    = 32'h00000000;
    htrans_i   = 2'b00;
    hwrite_i   = 1'b0;
    hwdata_i   = 32'h00000000;
    ain        = 8'h00;
    do_reset();
    t_reset_vals();
    t_fields();
    t_conv(1'b1, 8'hb6);
    t_stop(8'hb6);
    t_conv(1'b0, 8'h00);
    t_conv(1'b1, 8'hff);
    t_stop(8'hff);
    t_keep_on_reset(8'hff);
    report_and_stop();
  end
endmodule
